// ---- src/cpu_core_regs_pkg.sv ----
package cpu_core_regs_pkg;

  // Address map of the 64 KB space
  localparam int          ADDR_W          = 16;
  localparam logic [15:0] VEC_LO          = 16'h0000;
  localparam logic [15:0] VEC_HI          = 16'h0021;
  localparam logic [15:0] TBL_LO          = 16'h0040;
  localparam logic [15:0] TBL_HI          = 16'h007F;
  localparam logic [15:0] OPT_ADDR        = 16'h0080;
  localparam logic [15:0] RAM_BASE_SMALL  = 16'hFE80;
  localparam logic [15:0] RAM_BASE_LARGE  = 16'hFE00;
  localparam logic [15:0] PERIPH_BASE     = 16'hFF00;
  localparam logic [15:0] RESET_VEC_ADDR  = 16'h0000;

  // Flag word layout and reset value
  localparam logic [7:0]  FLAG_RESET      = 8'h02;
  localparam int          FLAG_IE_BIT     = 7;
  localparam int          FLAG_Z_BIT      = 6;
  localparam int          FLAG_HC_BIT     = 4;
  localparam int          FLAG_CY_BIT     = 0;

  // Register bus word offsets
  localparam logic [7:0]  OFS_FLAG        = 8'h00;
  localparam logic [7:0]  OFS_STACK       = 8'h04;
  localparam logic [7:0]  OFS_IPTR        = 8'h08;
  localparam logic [7:0]  OFS_GPR_LO      = 8'h0C;
  localparam logic [7:0]  OFS_GPR_HI      = 8'h10;
  localparam logic [7:0]  OFS_CMD         = 8'h14;
  localparam logic [7:0]  OFS_OPER        = 8'h18;
  localparam logic [7:0]  OFS_STATUS      = 8'h1C;
  localparam logic [7:0]  OFS_OPTION      = 8'h20;
  localparam logic [7:0]  OFS_PROBE       = 8'h24;
  localparam logic [7:0]  OFS_PROBE_RES   = 8'h28;

  // Commands written to the command register
  typedef enum logic [3:0] {
    CMD_NOP, CMD_ADVANCE, CMD_BRANCH_IMM, CMD_BRANCH_PAIR, CMD_MASK_ALL, CMD_UNMASK,
    CMD_PUSH_FLAGS, CMD_POP_FLAGS, CMD_IRQ_TAKE, CMD_IRQ_RETURN, CMD_ADD, CMD_SUB,
    CMD_ROT_LEFT, CMD_BIT_AND, CMD_TABLE_CALL, CMD_VEC_LOAD
  } cmd_e;

  // Command operand: register select, immediate and size/mask fields
  typedef struct packed {
    logic [2:0]  regSel;
    logic [15:0] imm;
    logic [3:0]  lenMask;
  } oper_s;

  // Region decode result
  typedef struct packed {
    logic vecArea;
    logic tblArea;
    logic optByte;
    logic ramArea;
    logic periph;
    logic misalign16;
  } region_s;

endpackage : cpu_core_regs_pkg

// ---- src/cpu_core_regs.sv ----
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

// Functional notes
// - A flat 16-bit space of 64 KB is decoded into regions.
// - Bytes 0000H-0021H are the vector table area.
// - Vector entries take low byte at even, high byte at odd address.
// - Table call reads its target from 0040H-007FH.
// - Address 0080H is the option byte, not program area.
// - RAM is 128 or 256 bytes, base FE80H or FE00H.
// - Peripheral window is FF00H-FFFFH.
// - Peripheral 16-bit accesses must use an even address.
// - Instruction pointer advances by length or loads on branch.
// - Reset loads the instruction pointer from 0000H/0001H.
// - Flag word pushed on interrupt or push, restored on return or pop.
// - Reset sets the flag word to 02H.
// - Gate flag 0 refuses maskable requests; 1 defers to source masks.
// - Gate cleared by mask-all or acknowledge, set by unmask.
// - Zero flag set on zero result, cleared otherwise.
// - Half-carry set on carry or borrow at bit 3.
// - Carry records overflow, rotate shift-out, and bit accumulation.
// - Stack pointer only addresses internal RAM.
// - Stack pointer decrements before save, increments after restore.
// - Stack pointer is undefined after reset; software must load it.
// - Eight 8-bit general registers, also four 16-bit pairs.
module cpu_core_regs
  import cpu_core_regs_pkg::*;
#(
  parameter bit LARGE_RAM = 1'b1  // 1: 256-byte RAM, 0: 128-byte RAM
) (
  input  wire logic        clk,         // System clock, 250 MHz
  input  wire logic        rst,         // Asynchronous reset, active high
  input  wire logic        clkEn,       // Freezes all state while low
  input  wire logic        wb_cyc_i,    // Wishbone cycle
  input  wire logic        wb_stb_i,    // Wishbone strobe
  input  wire logic        wb_we_i,     // Wishbone write enable
  input  wire logic [7:0]  wb_adr_i,    // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,    // Wishbone byte lanes
  input  wire logic [31:0] wb_dat_i,    // Wishbone write data
  output logic      [31:0] wb_dat_o,    // Wishbone read data
  output logic             wb_ack_o,    // Wishbone acknowledge
  input  wire logic [7:0]  memData,     // Byte read from program memory, same clock
  input  wire logic        irqMaskOk,   // Source mask flag allows the request
  output logic      [15:0] memAddr,     // Program memory byte address
  output logic             irqAccept,   // Maskable request would be accepted
  output logic      [15:0] stackAddr    // Current stack address
);

  typedef enum logic [2:0] {ST_IDLE, ST_VLO, ST_VHI, ST_DONE} fetch_e;

  logic [7:0]  flagWord_r;
  logic [15:0] stackTop_r;
  logic [15:0] iptr_r;
  logic [7:0]  gpr_r [8];
  logic [7:0]  savedFlags_r;
  logic [7:0]  optByte_r;
  logic [15:0] probe_r;
  logic        probeBad_r;
  region_s     probeRes_r;
  oper_s       oper_r;
  fetch_e      fetch_r;
  logic [15:0] fetchBase_r;
  logic [7:0]  fetchLo_r;
  logic        fetchToOpt_r;
  logic        bootDone_r;

  logic        wbReq;
  logic        wbWr;
  logic        cmdGo;
  cmd_e        cmdCode;
  logic [15:0] ramBase;
  logic [7:0]  opA;
  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic [7:0]  aluRes;
  logic        aluOp;

  // Decode a 16-bit address into its regions; used by the probe and stack guard
  function automatic region_s decode(input logic [15:0] a, input logic wide, input logic [15:0] rb);
    region_s r;
    r.vecArea    = (a >= VEC_LO) && (a <= VEC_HI);
    r.tblArea    = (a >= TBL_LO) && (a <= TBL_HI);
    r.optByte    = (a == OPT_ADDR);
    r.ramArea    = (a >= rb) && (a < PERIPH_BASE);
    r.periph     = (a >= PERIPH_BASE);
    r.misalign16 = r.periph && wide && a[0];
    return r;
  endfunction : decode

  // Zero-extend a 16-bit field for the read mux
  function automatic logic [31:0] ext16(input logic [15:0] v);
    return {16'h0000, v};
  endfunction : ext16

  assign ramBase = LARGE_RAM ? RAM_BASE_LARGE : RAM_BASE_SMALL;
  assign wbReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWr    = wbReq && wb_we_i && clkEn;
  assign cmdGo   = wbWr && (wb_adr_i == OFS_CMD) && wb_sel_i[0] && (fetch_r == ST_IDLE) && bootDone_r;
  assign cmdCode = cmd_e'(wb_dat_i[3:0]);

  // Arithmetic unit on the selected general register and the immediate low byte
  assign opA    = gpr_r[oper_r.regSel];
  assign sum9   = (cmdCode == CMD_SUB) ? ({1'b0, opA} - {1'b0, oper_r.imm[7:0]})
                                       : ({1'b0, opA} + {1'b0, oper_r.imm[7:0]});
  assign sum5   = (cmdCode == CMD_SUB) ? ({1'b0, opA[3:0]} - {1'b0, oper_r.imm[3:0]})
                                       : ({1'b0, opA[3:0]} + {1'b0, oper_r.imm[3:0]});
  assign aluOp  = cmdGo && ((cmdCode == CMD_ADD) || (cmdCode == CMD_SUB) || (cmdCode == CMD_ROT_LEFT));
  assign aluRes = (cmdCode == CMD_ROT_LEFT) ? {opA[6:0], flagWord_r[FLAG_CY_BIT]} : sum9[7:0];

  // Gate flag alone decides refusal; sources mask individually behind it
  assign irqAccept = flagWord_r[FLAG_IE_BIT] && irqMaskOk;
  assign stackAddr = stackTop_r;

  // Bus slave: one wait-free acknowledge per request, dropped the next cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else if (clkEn) begin
      wb_ack_o <= wbReq;
    end
  end

  // Read data mux; unmapped offsets read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (clkEn && wbReq && !wb_we_i) begin
      case (wb_adr_i)
        OFS_FLAG:      wb_dat_o <= {24'h000000, flagWord_r};
        OFS_STACK:     wb_dat_o <= ext16(stackTop_r);
        OFS_IPTR:      wb_dat_o <= ext16(iptr_r);
        OFS_GPR_LO:    wb_dat_o <= {gpr_r[3], gpr_r[2], gpr_r[1], gpr_r[0]};
        OFS_GPR_HI:    wb_dat_o <= {gpr_r[7], gpr_r[6], gpr_r[5], gpr_r[4]};
        OFS_OPER:      wb_dat_o <= {9'h000, oper_r};
        OFS_STATUS:    wb_dat_o <= {29'h0000_0000, probeBad_r, (fetch_r != ST_IDLE), bootDone_r};
        OFS_OPTION:    wb_dat_o <= {24'h000000, optByte_r};
        OFS_PROBE:     wb_dat_o <= ext16(probe_r);
        OFS_PROBE_RES: wb_dat_o <= {26'h0000000, probeRes_r};
        default:       wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Operand register for the commands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oper_r <= '0;
    end else if (wbWr && (wb_adr_i == OFS_OPER)) begin
      if (wb_sel_i[0]) oper_r.lenMask <= wb_dat_i[3:0];
      if (wb_sel_i[1]) oper_r.imm[7:0] <= wb_dat_i[11:4];
      if (wb_sel_i[2]) oper_r.imm[15:8] <= wb_dat_i[19:12];
      if (wb_sel_i[2]) oper_r.regSel <= wb_dat_i[22:20];
    end
  end

  // Address probe: software writes an address and reads back its region
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      probe_r    <= 16'h0000;
      probeRes_r <= '0;
    end else if (wbWr && (wb_adr_i == OFS_PROBE)) begin
      probe_r    <= wb_dat_i[15:0];
      probeRes_r <= decode(wb_dat_i[15:0], wb_dat_i[16], ramBase);
    end
  end

  // Vector/table fetch sequencer: low byte first, then high byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetch_r      <= ST_VLO;
      fetchBase_r  <= RESET_VEC_ADDR;
      fetchLo_r    <= 8'h00;
      fetchToOpt_r <= 1'b0;
      bootDone_r   <= 1'b0;
    end else if (clkEn) begin
      case (fetch_r)
        ST_IDLE: begin
          // Option byte is shown for one idle cycle only, then the pointer again
          fetchToOpt_r <= 1'b0;
          if (cmdGo && (cmdCode == CMD_TABLE_CALL)) begin
            fetchBase_r <= TBL_LO + {10'h000, oper_r.imm[4:0], 1'b0};
            fetch_r     <= ST_VLO;
          end else if (cmdGo && (cmdCode == CMD_VEC_LOAD || cmdCode == CMD_IRQ_TAKE)) begin
            fetchBase_r <= {10'h000, oper_r.imm[4:0], 1'b0};
            fetch_r     <= ST_VLO;
          end
        end
        ST_VLO: begin
          fetchLo_r <= memData;
          fetch_r   <= ST_VHI;
        end
        ST_VHI: begin
          fetch_r <= ST_DONE;
        end
        ST_DONE: begin
          fetchToOpt_r <= !bootDone_r;
          bootDone_r   <= 1'b1;
          fetch_r      <= ST_IDLE;
        end
        default: fetch_r <= ST_IDLE;
      endcase
    end
  end

  // Option byte is captured once after the reset vector, never as program
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      optByte_r <= 8'h00;
    end else if (clkEn && fetchToOpt_r && fetch_r == ST_IDLE) begin
      optByte_r <= memData;
    end
  end

  // Memory address: vector bytes while fetching, option byte once, else pointer
  always_comb begin
    case (fetch_r)
      ST_VLO:  memAddr = fetchBase_r;
      ST_VHI:  memAddr = fetchBase_r | 16'h0001;
      default: memAddr = fetchToOpt_r ? OPT_ADDR : iptr_r;
    endcase
  end

  // Instruction pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      iptr_r <= 16'h0000;
    end else if (clkEn) begin
      if (fetch_r == ST_VHI) begin
        iptr_r <= {memData, fetchLo_r};
      end else if (cmdGo) begin
        case (cmdCode)
          CMD_ADVANCE:     iptr_r <= iptr_r + {12'h000, oper_r.lenMask};
          CMD_BRANCH_IMM:  iptr_r <= oper_r.imm;
          CMD_BRANCH_PAIR: iptr_r <= {gpr_r[{oper_r.regSel[1:0], 1'b1}],
                                      gpr_r[{oper_r.regSel[1:0], 1'b0}]};
          default:         iptr_r <= iptr_r;
        endcase
      end
    end
  end

  // Flag word: gate, zero, half-carry and carry updates
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flagWord_r   <= FLAG_RESET;
      savedFlags_r <= FLAG_RESET;
    end else if (clkEn) begin
      if (wbWr && (wb_adr_i == OFS_FLAG) && wb_sel_i[0]) begin
        flagWord_r <= wb_dat_i[7:0];
      end else if (cmdGo) begin
        case (cmdCode)
          CMD_MASK_ALL:   flagWord_r[FLAG_IE_BIT] <= 1'b0;
          CMD_UNMASK:     flagWord_r[FLAG_IE_BIT] <= 1'b1;
          CMD_IRQ_TAKE: begin
            savedFlags_r            <= flagWord_r;
            flagWord_r[FLAG_IE_BIT] <= 1'b0;
          end
          CMD_PUSH_FLAGS: savedFlags_r <= flagWord_r;
          CMD_POP_FLAGS,
          CMD_IRQ_RETURN: flagWord_r <= savedFlags_r;
          CMD_ADD, CMD_SUB: begin
            flagWord_r[FLAG_Z_BIT]  <= (sum9[7:0] == 8'h00);
            flagWord_r[FLAG_HC_BIT] <= sum5[4];
            flagWord_r[FLAG_CY_BIT] <= sum9[8];
          end
          CMD_ROT_LEFT:   flagWord_r[FLAG_CY_BIT] <= opA[7];
          CMD_BIT_AND:    flagWord_r[FLAG_CY_BIT] <= flagWord_r[FLAG_CY_BIT] & opA[oper_r.lenMask[2:0]];
          default:        flagWord_r <= flagWord_r;
        endcase
      end
    end
  end

  // Stack pointer: no reset value, software loads it first
  always_ff @(posedge clk) begin
    if (clkEn) begin
      if (wbWr && (wb_adr_i == OFS_STACK)) begin
        if (wb_sel_i[0]) stackTop_r[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) stackTop_r[15:8] <= wb_dat_i[15:8];
      end else if (cmdGo && (cmdCode == CMD_PUSH_FLAGS || cmdCode == CMD_IRQ_TAKE)
                   && decode(stackTop_r - 16'h0001, 1'b0, ramBase).ramArea) begin
        stackTop_r <= stackTop_r - 16'h0001;
      end else if (cmdGo && (cmdCode == CMD_POP_FLAGS || cmdCode == CMD_IRQ_RETURN)
                   && decode(stackTop_r, 1'b0, ramBase).ramArea) begin
        stackTop_r <= stackTop_r + 16'h0001;
      end
    end
  end

  // Misalignment status of the last probe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      probeBad_r <= 1'b0;
    end else if (wbWr && (wb_adr_i == OFS_PROBE)) begin
      probeBad_r <= decode(wb_dat_i[15:0], wb_dat_i[16], ramBase).misalign16;
    end
  end

  // General registers: byte-lane writes, ALU results land in the selected one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) gpr_r[i] <= 8'h00;
    end else if (clkEn) begin
      if (wbWr && (wb_adr_i == OFS_GPR_LO || wb_adr_i == OFS_GPR_HI)) begin
        for (int i = 0; i < 4; i++) begin
          if (wb_sel_i[i]) gpr_r[{(wb_adr_i == OFS_GPR_HI), 2'(i)}] <= wb_dat_i[8*i +: 8];
        end
      end else if (aluOp) begin
        gpr_r[oper_r.regSel] <= aluRes;
      end
    end
  end

endmodule : cpu_core_regs

// ---- testbench/cpu_core_regs_properties.sv ----
`timescale 1ns/1ps
module cpu_core_regs_checker
  import cpu_core_regs_pkg::*;
#(
  parameter bit LARGE_RAM = 1'b1  // RAM size option
) (
  input wire logic        clk,        // Clock
  input wire logic        rst,        // Reset
  input wire logic        clkEn,      // Run enable
  input wire logic        wb_cyc_i,   // Bus cycle
  input wire logic        wb_stb_i,   // Bus strobe
  input wire logic        wb_we_i,    // Bus write
  input wire logic [7:0]  wb_adr_i,   // Bus address
  input wire logic [3:0]  wb_sel_i,   // Bus lanes
  input wire logic [31:0] wb_dat_i,   // Bus write data
  input wire logic [31:0] wb_dat_o,   // Bus read data
  input wire logic        wb_ack_o,   // Bus acknowledge
  input wire logic [7:0]  memData,    // Program byte
  input wire logic        irqMaskOk,  // Source mask
  input wire logic [15:0] memAddr,    // Program address
  input wire logic        irqAccept,  // Request accepted
  input wire logic [15:0] stackAddr   // Stack address
);
  localparam logic [15:0] RamLo = LARGE_RAM ? RAM_BASE_LARGE : RAM_BASE_SMALL;
  logic take;
  logic stkWr;
  // Request taken, and bus loads of the stack pointer which may jump anywhere
  assign take  = wb_cyc_i & wb_stb_i & ~wb_ack_o & clkEn;
  assign stkWr = take & wb_we_i & (wb_adr_i == OFS_STACK);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Boot reads the low vector byte, then the high one
  sequence boot_s;
    memAddr == RESET_VEC_ADDR ##1 memAddr == 16'h0001;
  endsequence
  a_boot_fetch: assert property ($past(rst) && clkEn |-> boot_s)
    else $error("boot fetch order wrong");
  a_ack_follows: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o && clkEn |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(take))
    else $error("ack without request");
  a_idle_quiet: assert property (!(wb_cyc_i && wb_stb_i) && clkEn |=> !wb_ack_o)
    else $error("ack while idle");
  a_rdata_hold: assert property (!$stable(wb_dat_o) |-> $past(take && !wb_we_i))
    else $error("read data moved without read");
  a_irq_mask: assert property (irqAccept |-> irqMaskOk)
    else $error("accept without source mask");
  a_stack_step: assert property (!$stable(stackAddr) && !$past(stkWr) |->
    stackAddr == $past(stackAddr) + 16'h0001 || stackAddr == $past(stackAddr) - 16'h0001)
    else $error("stack pointer jumped");
  a_stack_ram: assert property (!$stable(stackAddr) && !$past(stkWr) |-> stackAddr >= RamLo)
    else $error("stack left internal RAM");
endmodule : cpu_core_regs_checker

bind cpu_core_regs cpu_core_regs_checker #(.LARGE_RAM(LARGE_RAM)) i_chk (.clk, .rst, .clkEn, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .memData, .irqMaskOk,
  .memAddr, .irqAccept, .stackAddr);

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import cpu_core_regs_pkg::*;
;
  logic        clk, rst, cyc, stb, we, irqMaskOk, wb_ack_o, irqAccept;
  logic [7:0]  adr, lfsr, fl, im;
  logic [31:0] wdat, rd, wb_dat_o;
  logic [15:0] memAddr, stackAddr, ip;
  logic [7:0]  gpr [8];
  wire  [7:0]  memData;
  int          err_count, n_compared;
  localparam logic [16:0] PA [10] = '{17'h00000, 17'h00021, 17'h00022, 17'h00040, 17'h0007F,
    17'h00080, 17'h0FE00, 17'h0FEFF, 17'h1FF00, 17'h1FF01};
  localparam logic [5:0]  PE [10] = '{6'h20, 6'h20, 6'h00, 6'h10, 6'h10, 6'h08, 6'h04, 6'h04, 6'h02, 6'h03};
  // Program memory model: a fixed pattern, so every byte is predictable
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction : mb
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd
  assign memData = mb(memAddr);
  cpu_core_regs i_dut (.clk(clk), .rst(rst), .clkEn(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .memData(memData), .irqMaskOk(irqMaskOk), .memAddr(memAddr), .irqAccept(irqAccept),
    .stackAddr(stackAddr));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic end_sim();
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Classic cycle: hold the request until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 40) err_count++;
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  // Commands are dropped while a fetch runs, so poll busy before going on
  task automatic cmd(input cmd_e c, input logic [2:0] rs, input logic [15:0] v, input logic [3:0] ln);
    int n;
    wb(1'b1, OFS_OPER, {9'h0, rs, v, ln});
    wb(1'b1, OFS_CMD, {28'h0, c});
    n = 0;
    do begin wb(1'b0, OFS_STATUS, 32'h0); n++; end while (rd[1] !== 1'b0 && n < 10);
  endtask : cmd
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
  initial begin
    int n;
    logic [8:0] s;
    cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0; irqMaskOk = 1'b0; rst = 1'b1;
    err_count = 0; n_compared = 0; lfsr = 8'h32;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_FLAG, 32'h02);
    n = 0;
    do begin wb(1'b0, OFS_STATUS, 32'h0); n++; end while (rd[0] !== 1'b1 && n < 20);
    ip = {mb(16'h0001), mb(16'h0000)};
    rdc(OFS_IPTR, {16'h0, ip});
    rdc(OFS_OPTION, {24'h0, mb(OPT_ADDR)});
    cmd(CMD_ADVANCE, 3'h0, 16'h0, 4'hF);
    rdc(OFS_IPTR, {16'h0, ip + 16'h000F});
    ip = {rnd(), rnd()};
    cmd(CMD_BRANCH_IMM, 3'h0, ip, 4'h0);
    cmd(CMD_NOP, 3'h0, 16'h0, 4'h0);
    rdc(OFS_IPTR, {16'h0, ip});
    chk({16'h0, memAddr}, {16'h0, ip});
    for (int k = 0; k < 8; k++) gpr[k] = rnd();
    wb(1'b1, OFS_GPR_LO, {gpr[3], gpr[2], gpr[1], gpr[0]});
    wb(1'b1, OFS_GPR_HI, {gpr[7], gpr[6], gpr[5], gpr[4]});
    rdc(OFS_GPR_HI, {gpr[7], gpr[6], gpr[5], gpr[4]});
    for (int k = 0; k < 4; k++) begin
      cmd(CMD_BRANCH_PAIR, 3'(k), 16'h0, 4'h0);
      rdc(OFS_IPTR, {16'h0, gpr[2*k+1], gpr[2*k]});
    end
    // Alternate add and subtract; the last one subtracts the value itself
    wb(1'b1, OFS_FLAG, 32'h0);
    fl = 8'h00;
    for (int k = 0; k < 6; k++) begin
      im = (k == 5) ? gpr[0] : rnd();
      s = k[0] ? gpr[0] - im : gpr[0] + im;
      fl[4] = k[0] ? (im[3:0] > gpr[0][3:0]) : ((gpr[0][3:0] + im[3:0]) > 15);
      fl[0] = s[8];
      fl[6] = (s[7:0] == 8'h00);
      gpr[0] = s[7:0];
      cmd(k[0] ? CMD_SUB : CMD_ADD, 3'h0, {8'h0, im}, 4'h0);
      rdc(OFS_FLAG, {24'h0, fl});
    end
    gpr[0] = rnd();
    wb(1'b1, OFS_GPR_LO, {gpr[3], gpr[2], gpr[1], gpr[0]});
    cmd(CMD_ROT_LEFT, 3'h0, 16'h0, 4'h0);
    {fl[0], gpr[0]} = {gpr[0], fl[0]};
    rdc(OFS_GPR_LO, {gpr[3], gpr[2], gpr[1], gpr[0]});
    rdc(OFS_FLAG, {24'h0, fl});
    cmd(CMD_BIT_AND, 3'h1, 16'h0, 4'h5);
    wb(1'b0, OFS_FLAG, 32'h0);
    chk({31'h0, rd[0]}, {31'h0, fl[0] & gpr[1][5]});
    irqMaskOk <= 1'b1;
    wb(1'b1, OFS_FLAG, 32'h91);
    @(negedge clk);
    chk({31'h0, irqAccept}, 32'h1);
    cmd(CMD_MASK_ALL, 3'h0, 16'h0, 4'h0);
    @(negedge clk);
    chk({31'h0, irqAccept}, 32'h0);
    cmd(CMD_UNMASK, 3'h0, 16'h0, 4'h0);
    rdc(OFS_FLAG, 32'h91);
    irqMaskOk <= 1'b0;
    @(negedge clk);
    chk({31'h0, irqAccept}, 32'h0);
    wb(1'b1, OFS_STACK, 32'h0000FE40);
    cmd(CMD_PUSH_FLAGS, 3'h0, 16'h0, 4'h0);
    chk({16'h0, stackAddr}, 32'hFE3F);
    wb(1'b1, OFS_FLAG, 32'h0);
    cmd(CMD_POP_FLAGS, 3'h0, 16'h0, 4'h0);
    chk({16'h0, stackAddr}, 32'hFE40);
    rdc(OFS_FLAG, 32'h91);
    cmd(CMD_IRQ_TAKE, 3'h0, 16'h0004, 4'h0);
    rdc(OFS_IPTR, {16'h0, mb(16'h0009), mb(16'h0008)});
    rdc(OFS_FLAG, 32'h11);
    chk({16'h0, stackAddr}, 32'hFE3F);
    cmd(CMD_IRQ_RETURN, 3'h0, 16'h0, 4'h0);
    rdc(OFS_FLAG, 32'h91);
    cmd(CMD_TABLE_CALL, 3'h0, 16'h0002, 4'h0);
    rdc(OFS_IPTR, {16'h0, mb(16'h0045), mb(16'h0044)});
    cmd(CMD_VEC_LOAD, 3'h0, 16'h0010, 4'h0);
    rdc(OFS_IPTR, {16'h0, mb(16'h0021), mb(16'h0020)});
    wb(1'b1, OFS_STACK, 32'h0000FE00);
    cmd(CMD_PUSH_FLAGS, 3'h0, 16'h0, 4'h0);
    chk({16'h0, stackAddr}, 32'hFE00);
    // Region decode at each boundary of the map
    for (int k = 0; k < 10; k++) begin
      wb(1'b1, OFS_PROBE, {15'h0, PA[k]});
      rdc(OFS_PROBE_RES, {26'h0, PE[k]});
    end
    rdc(OFS_STATUS, 32'h5);
    rdc(8'hFC, 32'h0);
    end_sim();
  end
endmodule : tb_top
